/* bench/swc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
	// Clock
	input  wire logic clk,
	// Core side
	input  wire logic cpu_clk_en,
	output logic      sleep_exec,
	output logic      instr_retire
);
	initial begin
		sleep_exec = 1'h0;
	end

	// One instruction per ungated cycle, none while the clock is gated
	always @(negedge clk) instr_retire <= cpu_clk_en;

	task automatic do_sleep();
		@(negedge clk);
		sleep_exec <= 1'h1;
		@(negedge clk);
		sleep_exec <= 1'h0;
	endtask
endmodule // swc_core_model
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
	logic        clk, rst_n, sleep_exec, clrwdt_exec, instr_retire, global_irq_enable;
	logic        cpu_clk_en, sleep_nop, resume, isr_vector_req;
	logic [15:0] isr_vector_addr;
	logic [7:0]  irq_flag, irq_enable, vreg_ctrl_wdata, vreg_ctrl_rdata;
	logic        wdt_enabled, wdt_sleep_enable, wdt_timeout, wdt_clear, wdt_count_en;
	logic        master_clear_pin_n, master_clear_enable, brownout_reset, brownout_enable;
	logic        power_on_reset, device_reset, two_speed_start, adc_src_dedicated_rc, vreg_ctrl_we;
	logic [2:0]  osc_mode;
	logic [1:0]  timer1_clk_src;
	logic        power_down_flag, timeout_flag, asleep, wake_delay_busy, io_hold;
	logic        low_freq_osc_run, timer1_clk_en, adc_clk_en, regulator_low_power;
	int          fail_count, compares, m_pd, m_to, n;

	swc_sleep_ctrl swc_sleep_ctrl_inst (.clk, .rst_n, .sleep_exec, .clrwdt_exec, .instr_retire,
		.global_irq_enable, .cpu_clk_en, .sleep_nop, .resume, .isr_vector_req, .isr_vector_addr,
		.irq_flag, .irq_enable, .wdt_enabled, .wdt_sleep_enable, .wdt_timeout, .wdt_clear,
		.wdt_count_en, .master_clear_pin_n, .master_clear_enable, .brownout_reset, .brownout_enable,
		.power_on_reset, .device_reset, .osc_mode, .two_speed_start, .timer1_clk_src,
		.adc_src_dedicated_rc, .vreg_ctrl_we, .vreg_ctrl_wdata, .vreg_ctrl_rdata, .power_down_flag,
		.timeout_flag, .asleep, .wake_delay_busy, .io_hold, .low_freq_osc_run, .timer1_clk_en,
		.adc_clk_en, .regulator_low_power);
	swc_core_model swc_core_model_inst (.clk, .cpu_clk_en, .sleep_exec, .instr_retire);

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		fail_count++;
		end_of_test();
	end

	// Cycles spent in the wake wait, including the final one
	function automatic int wake_len(logic [2:0] m, logic ts, int sel);
		wake_len = 1 + sel * swc_pkg::LP_WAKE_CYCLES_I;
		if (!ts && (m == swc_pkg::OSC_LP || m == swc_pkg::OSC_XT || m == swc_pkg::OSC_HS))
			wake_len += swc_pkg::OST_PERIODS;
	endfunction

	task automatic chk_flags();
		`CHK("power_down_flag", m_pd, power_down_flag)
		`CHK("timeout_flag", m_to, timeout_flag)
	endtask

	task automatic clear_wdt();
		clrwdt_exec = 1'h1;
		@(negedge clk);
		clrwdt_exec = 1'h0;
		m_pd = 1;
		m_to = 1;
	endtask

	task automatic sleep_case(logic [2:0] m, logic ts, int sel, logic g, logic wd);
		int i;
		int cnt;
		int seen;
		osc_mode = m;
		two_speed_start = ts;
		global_irq_enable = g;
		wdt_enabled = 1'h1;
		wdt_sleep_enable = wd;
		timer1_clk_src = 2'($urandom);
		adc_src_dedicated_rc = 1'($urandom);
		i = $urandom_range(swc_pkg::NUM_IRQ - 1);
		vreg_ctrl_wdata = {6'($urandom), sel[0], 1'($urandom)};
		vreg_ctrl_we = 1'h1;
		@(negedge clk);
		vreg_ctrl_we = 1'h0;
		`CHK("vreg_ctrl_rdata", {6'h0, sel[0], 1'h1}, vreg_ctrl_rdata)
		clear_wdt();
		swc_core_model_inst.do_sleep();
		m_pd = 0;
		chk_flags();
		`CHK("asleep", 1, asleep)
		`CHK("wdt_clear", 1, wdt_clear)
		`CHK("wdt_count_en", wd, wdt_count_en)
		`CHK("cpu_clk_en", 0, cpu_clk_en)
		`CHK("io_hold", 1, io_hold)
		`CHK("low_freq_osc_run", 1, low_freq_osc_run)
		`CHK("timer1_clk_en", timer1_clk_src != swc_pkg::T1_FOSC, timer1_clk_en)
		`CHK("adc_clk_en", adc_src_dedicated_rc, adc_clk_en)
		`CHK("regulator_low_power", sel, regulator_low_power)
		irq_flag[i] = 1'h1;
		repeat (3) @(negedge clk);
		`CHK("asleep", 1, asleep)
		`CHK("instr_retire", 0, instr_retire)
		if (wd) wdt_timeout = 1'h1;
		else irq_enable[i] = 1'h1;
		@(negedge clk);
		wdt_timeout = 1'h0;
		irq_flag = 8'h00;
		irq_enable = 8'h00;
		if (wd) m_to = 0;
		chk_flags();
		`CHK("wdt_clear", 1, wdt_clear)
		cnt = 0;
		while (wake_delay_busy === 1'h1 && cnt < 3000) begin
			cnt++;
			@(negedge clk);
		end
		`CHK("wake_wait", wake_len(m, ts, sel), cnt)
		`CHK("resume", 1, resume)
		`CHK("cpu_clk_en", 1, cpu_clk_en)
		seen = 0;
		repeat (4) begin
			@(negedge clk);
			if (isr_vector_req === 1'h1) seen = 1;
		end
		`CHK("isr_vector_req", g, seen)
		`CHK("isr_vector_addr", 16'h0004, isr_vector_addr)
	endtask

	initial begin
		void'($urandom(32'h2401));
		{rst_n, clrwdt_exec, global_irq_enable, wdt_enabled, wdt_sleep_enable, wdt_timeout} = '0;
		{master_clear_enable, brownout_reset, brownout_enable, power_on_reset} = '0;
		{two_speed_start, adc_src_dedicated_rc, vreg_ctrl_we, osc_mode, timer1_clk_src} = '0;
		{irq_flag, irq_enable, vreg_ctrl_wdata} = '0;
		master_clear_pin_n = 1'h1;
		repeat (5) @(negedge clk);
		rst_n = 1'h1;
		@(negedge clk);
		`CHK("vreg_ctrl_rdata", 8'h01, vreg_ctrl_rdata)
		sleep_case(swc_pkg::OSC_EC, 1'h0, 0, 1'h0, 1'h0);
		sleep_case(swc_pkg::OSC_XT, 1'h0, 0, 1'h1, 1'h0);
		sleep_case(swc_pkg::OSC_HS, 1'h1, 0, 1'h0, 1'h1);
		sleep_case(swc_pkg::OSC_LP, 1'h0, 1, 1'h1, 1'h0);
		sleep_case(swc_pkg::OSC_RC, 1'h0, 1, 1'h0, 1'h0);
		sleep_case(swc_pkg::OSC_INTOSC, 1'h0, 0, 1'h0, 1'h1);
		// Enabled interrupt already pending when sleep is issued
		clear_wdt();
		global_irq_enable = 1'h0;
		irq_flag = 8'h01;
		irq_enable = 8'h01;
		swc_core_model_inst.do_sleep();
		`CHK("sleep_nop", 1, sleep_nop)
		`CHK("asleep", 0, asleep)
		`CHK("wdt_clear", 0, wdt_clear)
		chk_flags();
		global_irq_enable = 1'h1;
		swc_core_model_inst.do_sleep();
		m_pd = 0;
		chk_flags();
		n = 0;
		while (resume !== 1'h1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		`CHK("resume", 1, resume)
		{irq_flag, irq_enable, global_irq_enable} = '0;
		repeat (4) @(negedge clk);
		// Reset-type wake: pin, brownout, power-on, then brownout disabled
		master_clear_enable = 1'h1;
		brownout_enable = 1'h1;
		for (int k = 0; k < 4; k++) begin
			swc_core_model_inst.do_sleep();
			brownout_enable = (k != 3);
			master_clear_pin_n = (k != 0);
			brownout_reset = (k == 1 || k == 3);
			power_on_reset = (k == 2);
			n = 0;
			while (device_reset !== 1'h1 && n < 8) begin
				n++;
				@(negedge clk);
			end
			`CHK("device_reset", k != 3, device_reset)
			`CHK("asleep", k == 3, asleep)
			if (k != 3) begin
				m_pd = 1;
				m_to = 1;
				chk_flags();
			end
			{brownout_reset, power_on_reset} = '0;
			master_clear_pin_n = 1'h1;
			repeat (8) @(negedge clk);
		end
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire

/* rtl/swc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module swc_pin_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin and result
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic q1;
		logic q2;
		logic q3;
		logic lvl;
	} swc_sync_s;

	swc_sync_s s_reg;
	swc_sync_s s_next;

	always_comb begin
		s_next = s_reg;
		s_next.q1 = pin;
		s_next.q2 = s_reg.q1;
		s_next.q3 = s_reg.q2;
		// A change counts once stages two and three agree
		if (s_reg.q2 == s_reg.q3) begin
			s_next.lvl = s_reg.q3;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '{q1: 1'h1, q2: 1'h1, q3: 1'h1, lvl: 1'h1};
		end else begin
			s_reg <= s_next;
		end
	end

	assign level = s_reg.lvl;
endmodule // swc_pin_sync
`default_nettype wire

/* rtl/swc_pkg.sv */
`default_nettype none
package swc_pkg;
	// Controller states
	typedef enum logic [1:0] {
		ST_AWAKE,
		ST_ASLEEP,
		ST_WAKE_WAIT,
		ST_VECTOR
	} swc_state_e;

	// Interrupt lines watched for wake-up
	localparam int NUM_IRQ = 8;

	// Clock figures
	localparam int CLK_PERIOD_NS = 50;

	// Oscillator start-up wait, in oscillator periods
	localparam int OST_PERIODS = 1024;
	localparam int WAKE_CNT_W = 12;
	localparam logic [WAKE_CNT_W-1:0] OST_CYCLES = 12'(OST_PERIODS);

	// Regulator stabilisation after low-power sleep
	localparam int LP_WAKE_TIME_NS = 5000;
	localparam int LP_WAKE_CYCLES_I = (LP_WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [WAKE_CNT_W-1:0] LP_WAKE_CYCLES = 12'(LP_WAKE_CYCLES_I);

	// Interrupt service entry address
	localparam logic [15:0] ISR_VECTOR = 16'h0004;

	// Regulator control register layout
	localparam int VREG_PM_BIT = 1;
	localparam int VREG_RSVD_BIT = 0;
	localparam logic VREG_PM_RESET = 1'h0;
	localparam logic [7:0] VREG_RSVD_MASK = 8'h01;

	// Status flag values after reset
	localparam logic PD_RESET = 1'h1;
	localparam logic TO_RESET = 1'h1;

	// Oscillator modes
	localparam logic [2:0] OSC_EC = 3'h0;
	localparam logic [2:0] OSC_LP = 3'h1;
	localparam logic [2:0] OSC_XT = 3'h2;
	localparam logic [2:0] OSC_HS = 3'h3;
	localparam logic [2:0] OSC_RC = 3'h4;
	localparam logic [2:0] OSC_INTOSC = 3'h5;

	// Timer1 clock sources
	localparam logic [1:0] T1_FOSC = 2'h0;
	localparam logic [1:0] T1_LOW_FREQ_INTERNAL_OSC = 2'h1;
	localparam logic [1:0] T1_PIN = 2'h2;
	localparam logic [1:0] T1_SOSC = 2'h3;
endpackage
`default_nettype wire

/* rtl/swc_sleep_ctrl.sv */
// Summary of operation
// - Sleep instruction enters power-down mode
// - Entry clears watchdog; keeps counting if enabled
// - Entry clears power_down_flag
// - Entry sets timeout_flag
// - Processor clock gated off while asleep
// - Low-frequency oscillator and its peripherals keep running
// - Timer1 runs on slow, pin or secondary clock
// - Converter runs asleep on its dedicated oscillator
// - Port pins hold their drive state
// - Non-watchdog resets behave the same asleep
// - Pin, brownout, power-on reset wake by reset
// - Watchdog and interrupts wake and resume execution
// - Interrupt wakes only with its enable set
// - Global disable: resume after sleep instruction
// - Global enable: next instruction, then vector 0004h
// - Every wake clears the watchdog
// - Pending interrupt, global disable: sleep is no-op
// - Interrupt during sleep: complete, wake at once
// - Crystal modes without two-speed start wait 1024 oscillator periods
// - Low-power select lowers regulator during sleep
// - Low-power sleep adds stabilisation delay on wake
// - Select bit is bit 1, resets 0
`timescale 1ns/1ps
`default_nettype none
module swc_sleep_ctrl (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// Processor core
	input  wire logic                        sleep_exec,
	input  wire logic                        clrwdt_exec,
	input  wire logic                        instr_retire,
	input  wire logic                        global_irq_enable,
	output logic                             cpu_clk_en,
	output logic                             sleep_nop,
	output logic                             resume,
	output logic                             isr_vector_req,
	output logic [15:0]                      isr_vector_addr,
	// Interrupt requests
	input  wire logic [swc_pkg::NUM_IRQ-1:0] irq_flag,
	input  wire logic [swc_pkg::NUM_IRQ-1:0] irq_enable,
	// Watchdog
	input  wire logic                        wdt_enabled,
	input  wire logic                        wdt_sleep_enable,
	input  wire logic                        wdt_timeout,
	output logic                             wdt_clear,
	output logic                             wdt_count_en,
	// Reset sources
	input  wire logic                        master_clear_pin_n,
	input  wire logic                        master_clear_enable,
	input  wire logic                        brownout_reset,
	input  wire logic                        brownout_enable,
	input  wire logic                        power_on_reset,
	output logic                             device_reset,
	// Clock configuration
	input  wire logic [2:0]                  osc_mode,
	input  wire logic                        two_speed_start,
	input  wire logic [1:0]                  timer1_clk_src,
	input  wire logic                        adc_src_dedicated_rc,
	// Regulator control register
	input  wire logic                        vreg_ctrl_we,
	input  wire logic [7:0]                  vreg_ctrl_wdata,
	output logic [7:0]                       vreg_ctrl_rdata,
	// Status and power outputs
	output logic                             power_down_flag,
	output logic                             timeout_flag,
	output logic                             asleep,
	output logic                             wake_delay_busy,
	output logic                             io_hold,
	output logic                             low_freq_osc_run,
	output logic                             timer1_clk_en,
	output logic                             adc_clk_en,
	output logic                             regulator_low_power
);
	typedef struct packed {
		swc_pkg::swc_state_e state;
		logic                pd;
		logic                to;
		logic                regulator_sleep_power_select;
		logic                nop;
		logic                wdt_clr;
		logic                resume;
		logic                vec_req;
		logic                vec_pending;
		logic                rst_out;
	} swc_ctrl_s;

	swc_ctrl_s c_reg;
	swc_ctrl_s c_next;

	logic                              master_clear_pin_level_n;
	logic                              irq_pending;
	logic                              wdt_wake;
	logic                              reset_req;
	logic                              wake_any;
	logic                              timer_start;
	logic [swc_pkg::WAKE_CNT_W-1:0]    wake_load;
	logic                              timer_busy;

	// Crystal modes need the oscillator start-up wait
	function automatic logic is_crystal(input logic [2:0] mode);
		is_crystal = (mode == swc_pkg::OSC_LP) || (mode == swc_pkg::OSC_XT) ||
			(mode == swc_pkg::OSC_HS);
	endfunction

	swc_pin_sync u_master_clear_pin_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (master_clear_pin_n),
		.level (master_clear_pin_level_n)
	);

	swc_wake_timer u_wake_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.start (timer_start),
		.load  (wake_load),
		.busy  (timer_busy)
	);

	assign irq_pending = |(irq_flag & irq_enable);
	assign wdt_wake = wdt_timeout && wdt_enabled && wdt_sleep_enable;
	// Reset sources act identically asleep or awake
	assign reset_req = (!master_clear_pin_level_n && master_clear_enable) ||
		(brownout_reset && brownout_enable) || power_on_reset;
	assign wake_any = irq_pending || wdt_wake;

	// Start-up wait plus regulator settling
	assign wake_load = (is_crystal(osc_mode) && !two_speed_start ? swc_pkg::OST_CYCLES : 12'h000) +
		(c_reg.regulator_sleep_power_select ? swc_pkg::LP_WAKE_CYCLES : 12'h000);
	assign timer_start = (c_reg.state == swc_pkg::ST_ASLEEP) && wake_any && !reset_req;

	always_comb begin
		c_next = c_reg;
		c_next.nop = 1'h0;
		c_next.wdt_clr = 1'h0;
		c_next.resume = 1'h0;
		c_next.vec_req = 1'h0;
		c_next.rst_out = reset_req;
		if (vreg_ctrl_we) begin
			c_next.regulator_sleep_power_select = vreg_ctrl_wdata[swc_pkg::VREG_PM_BIT];
		end
		if (reset_req) begin
			// Full reset ends sleep and restores the flags
			c_next.state = swc_pkg::ST_AWAKE;
			c_next.pd = swc_pkg::PD_RESET;
			c_next.to = swc_pkg::TO_RESET;
			c_next.vec_pending = 1'h0;
			c_next.wdt_clr = 1'h1;
		end else begin
			case (c_reg.state)
				swc_pkg::ST_AWAKE: begin
					if (clrwdt_exec) begin
						c_next.pd = 1'h1;
						c_next.to = 1'h1;
						c_next.wdt_clr = 1'h1;
					end
					if (sleep_exec) begin
						if (irq_pending && !global_irq_enable) begin
							c_next.nop = 1'h1;
						end else begin
							c_next.state = swc_pkg::ST_ASLEEP;
							c_next.pd = 1'h0;
							c_next.to = 1'h1;
							c_next.wdt_clr = 1'h1;
						end
					end
				end
				swc_pkg::ST_ASLEEP: begin
					// An interrupt raised during entry is seen here and wakes at once
					if (wake_any) begin
						c_next.state = swc_pkg::ST_WAKE_WAIT;
						c_next.wdt_clr = 1'h1;
						c_next.vec_pending = irq_pending && global_irq_enable;
						if (wdt_wake && !irq_pending) begin
							c_next.to = 1'h0;
						end
					end
				end
				swc_pkg::ST_WAKE_WAIT: begin
					if (!timer_busy) begin
						c_next.resume = 1'h1;
						c_next.state = c_reg.vec_pending ? swc_pkg::ST_VECTOR : swc_pkg::ST_AWAKE;
					end
				end
				swc_pkg::ST_VECTOR: begin
					// Prefetched instruction retires before the service call
					if (instr_retire) begin
						c_next.vec_req = 1'h1;
						c_next.vec_pending = 1'h0;
						c_next.state = swc_pkg::ST_AWAKE;
					end
				end
				default: begin
					c_next.state = swc_pkg::ST_AWAKE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			c_reg <= '{state: swc_pkg::ST_AWAKE, pd: swc_pkg::PD_RESET, to: swc_pkg::TO_RESET,
				regulator_sleep_power_select: swc_pkg::VREG_PM_RESET, nop: 1'h0, wdt_clr: 1'h0, resume: 1'h0,
				vec_req: 1'h0, vec_pending: 1'h0, rst_out: 1'h0};
		end else begin
			c_reg <= c_next;
		end
	end

	assign asleep = (c_reg.state == swc_pkg::ST_ASLEEP) || (c_reg.state == swc_pkg::ST_WAKE_WAIT);
	assign cpu_clk_en = !asleep;
	assign wake_delay_busy = (c_reg.state == swc_pkg::ST_WAKE_WAIT);
	assign sleep_nop = c_reg.nop;
	assign resume = c_reg.resume;
	assign isr_vector_req = c_reg.vec_req;
	assign isr_vector_addr = swc_pkg::ISR_VECTOR;
	assign wdt_clear = c_reg.wdt_clr;
	assign wdt_count_en = wdt_enabled && (!asleep || wdt_sleep_enable);
	assign device_reset = c_reg.rst_out;
	assign power_down_flag = c_reg.pd;
	assign timeout_flag = c_reg.to;
	assign io_hold = asleep;
	assign low_freq_osc_run = 1'h1;
	assign timer1_clk_en = !asleep || (timer1_clk_src != swc_pkg::T1_FOSC);
	assign adc_clk_en = !asleep || adc_src_dedicated_rc;
	assign regulator_low_power = (c_reg.state == swc_pkg::ST_ASLEEP) && c_reg.regulator_sleep_power_select;
	assign vreg_ctrl_rdata = swc_pkg::VREG_RSVD_MASK |
		({7'h00, c_reg.regulator_sleep_power_select} << swc_pkg::VREG_PM_BIT);

	// Checks
	sequence s_sleep_taken;
		(c_reg.state == swc_pkg::ST_AWAKE) && sleep_exec && !reset_req &&
			!(irq_pending && !global_irq_enable);
	endsequence

	sequence s_sleep_refused;
		(c_reg.state == swc_pkg::ST_AWAKE) && sleep_exec && !reset_req &&
			irq_pending && !global_irq_enable;
	endsequence

	sequence s_crystal_wake;
		timer_start && is_crystal(osc_mode) && !two_speed_start;
	endsequence

	sequence s_lp_wake;
		timer_start && c_reg.regulator_sleep_power_select;
	endsequence

	chk_entry_flags: assert property (@(posedge clk) disable iff (!rst_n)
		s_sleep_taken |=> !power_down_flag && timeout_flag && !cpu_clk_en)
		else $error("sleep entry flags wrong");

	chk_entry_wdt_clear: assert property (@(posedge clk) disable iff (!rst_n)
		s_sleep_taken |=> wdt_clear ##1 (!wdt_clear || wake_delay_busy || device_reset))
		else $error("watchdog not cleared once on sleep entry");

	chk_nop_keeps_flags: assert property (@(posedge clk) disable iff (!rst_n)
		s_sleep_refused |=> sleep_nop && !wdt_clear && cpu_clk_en &&
			power_down_flag == $past(power_down_flag) && timeout_flag == $past(timeout_flag))
		else $error("refused sleep changed state");

	chk_no_wake_unenabled: assert property (@(posedge clk) disable iff (!rst_n)
		(c_reg.state == swc_pkg::ST_ASLEEP) && !irq_pending && !wdt_wake && !reset_req |=>
			(c_reg.state == swc_pkg::ST_ASLEEP))
		else $error("woke without enabled source");

	chk_wake_clears_wdt: assert property (@(posedge clk) disable iff (!rst_n)
		timer_start |=> wdt_clear && wake_delay_busy)
		else $error("wake did not clear watchdog");

	chk_crystal_wait: assert property (@(posedge clk) disable iff (!rst_n || reset_req)
		s_crystal_wake |=> wake_delay_busy [*8] ##0 !cpu_clk_en)
		else $error("crystal start-up wait skipped");

	chk_fast_wake: assert property (@(posedge clk) disable iff (!rst_n)
		timer_start && !is_crystal(osc_mode) && !c_reg.regulator_sleep_power_select |=> ##1 (resume || device_reset))
		else $error("normal wake delayed");

	chk_vector_after_next: assert property (@(posedge clk) disable iff (!rst_n)
		(c_reg.state == swc_pkg::ST_VECTOR) && instr_retire && !reset_req |=>
			isr_vector_req && isr_vector_addr == 16'h0004)
		else $error("service vector not requested");

	chk_no_vector_gie_off: assert property (@(posedge clk) disable iff (!rst_n)
		timer_start && !global_irq_enable |=> !c_reg.vec_pending)
		else $error("vector scheduled with global enable clear");

	chk_full_reset: assert property (@(posedge clk) disable iff (!rst_n)
		reset_req |=> device_reset && cpu_clk_en && power_down_flag && timeout_flag)
		else $error("reset wake wrong");

	chk_low_power_reg: assert property (@(posedge clk) disable iff (!rst_n)
		s_sleep_taken ##0 c_reg.regulator_sleep_power_select && !vreg_ctrl_we |=> regulator_low_power)
		else $error("regulator not lowered in sleep");

	chk_vreg_write: assert property (@(posedge clk) disable iff (!rst_n)
		vreg_ctrl_we |=> vreg_ctrl_rdata == {6'h00, $past(vreg_ctrl_wdata[1]), 1'h1})
		else $error("regulator control readback wrong");

	chk_flags_hold_asleep: assert property (@(posedge clk) disable iff (!rst_n)
		(c_reg.state == swc_pkg::ST_ASLEEP) && !wake_any && !reset_req |=>
			!power_down_flag && timeout_flag)
		else $error("status flags moved while asleep");

	chk_wdt_sleep_count: assert property (@(posedge clk) disable iff (!rst_n)
		asleep && wdt_enabled |-> wdt_count_en == wdt_sleep_enable)
		else $error("watchdog sleep counting wrong");

	chk_core_gated: assert property (@(posedge clk) disable iff (!rst_n)
		asleep |-> !cpu_clk_en && !resume && !isr_vector_req)
		else $error("core active while asleep");

	chk_sleep_clocks: assert property (@(posedge clk) disable iff (!rst_n)
		asleep |-> low_freq_osc_run && (adc_clk_en == adc_src_dedicated_rc) &&
			(timer1_clk_en == (timer1_clk_src != swc_pkg::T1_FOSC)))
		else $error("sleep clock enables wrong");

	chk_wdt_wake_flags: assert property (@(posedge clk) disable iff (!rst_n)
		timer_start && wdt_wake && !irq_pending |=> !timeout_flag && !power_down_flag)
		else $error("watchdog wake flags wrong");

	chk_irq_wake_flags: assert property (@(posedge clk) disable iff (!rst_n)
		timer_start && irq_pending |=> timeout_flag && !power_down_flag)
		else $error("interrupt wake flags wrong");

	chk_lp_wake_delay: assert property (@(posedge clk) disable iff (!rst_n || reset_req)
		s_lp_wake |=> wake_delay_busy [*8] ##0 !cpu_clk_en)
		else $error("low-power wake delay skipped");

	chk_resume_awake: assert property (@(posedge clk) disable iff (!rst_n)
		resume |-> cpu_clk_en && !asleep && !device_reset)
		else $error("resume without running core");

	chk_regulator_awake: assert property (@(posedge clk) disable iff (!rst_n)
		!asleep |-> !regulator_low_power)
		else $error("regulator lowered while awake");

	chk_vector_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		isr_vector_req |=> !isr_vector_req && !c_reg.vec_pending)
		else $error("service vector repeated");
endmodule // swc_sleep_ctrl
`default_nettype wire

/* rtl/swc_wake_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module swc_wake_timer (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// Control
	input  wire logic                           start,
	input  wire logic [swc_pkg::WAKE_CNT_W-1:0] load,
	output logic                                busy
);
	typedef struct packed {
		logic [swc_pkg::WAKE_CNT_W-1:0] cnt;
	} swc_timer_s;

	swc_timer_s t_reg;
	swc_timer_s t_next;

	always_comb begin
		t_next = t_reg;
		if (start) begin
			t_next.cnt = load;
		end else if (t_reg.cnt != '0) begin
			t_next.cnt = t_reg.cnt - 12'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign busy = (t_reg.cnt != '0);
endmodule // swc_wake_timer
`default_nettype wire
